//--- rtl/sslc_regs.sv
// Wishbone register slice for sync and serial lane configuration
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ns
module sslc_regs
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_sync,
    input wire logic [1:0] i_divider_phase,
    output logic [15:0] o_scan_vector,
    output logic o_scan_load,
    output logic o_align_enable,
    output logic o_sync_delay_enable,
    output logic [7:0] o_sync_delay_value,
    output logic o_training_mode,
    output logic [1:0] o_line_preemphasis_level,
    output logic [1:0] o_line_common_level_sel,
    output logic [1:0] o_line_swing_sel,
    output logic [9:0] o_lane_test_config
);
    import sslc_pkg::*;

    // ****************************************
    // Bus decode
    // ****************************************
    logic [15:0] scan_reg;
    logic [15:0] rsvd_reg;
    logic [15:0] align_reg;
    logic [15:0] line_reg;
    logic [15:0] ctrl_reg;
    logic [1:0] phase_reg;
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic req;
    logic wr;
    logic [15:0] rd_next;

    // Ack blocked only in the cycle after an ack, so a held request yields a one-cycle pulse every other cycle
    assign req = i_wb_cyc & i_wb_stb & ~ack_reg;
    assign wr = req & i_wb_we;

    // Merge write data by byte lane
    function automatic logic [15:0] sslc_merge(input logic [15:0] old,
        input logic [31:0] dat, input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0])
        begin
            r[7:0] = dat[7:0];
        end
        if (sel[1])
        begin
            r[15:8] = dat[15:8];
        end
        return r;
    endfunction

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= req;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            scan_reg <= SSLC_RST_SCAN;
            rsvd_reg <= SSLC_RST_RSVD;
            align_reg <= SSLC_RST_ALIGN;
            line_reg <= SSLC_RST_LINE;
            ctrl_reg <= SSLC_RST_CTRL;
        end
        else if (wr)
        begin
            if (i_wb_adr == SSLC_IDX_SCAN)
            begin
                scan_reg <= sslc_merge(scan_reg, i_wb_dat, i_wb_sel);
            end
            else if (i_wb_adr == SSLC_IDX_RSVD)
            begin
                // Stored as written; host keeps it at one
                rsvd_reg <= sslc_merge(rsvd_reg, i_wb_dat, i_wb_sel);
            end
            else if (i_wb_adr == SSLC_IDX_ALIGN)
            begin
                // Phase bits are read only; low reserved bits held at zero
                align_reg <= sslc_merge(align_reg, i_wb_dat, i_wb_sel)
                    & 16'hff80;
            end
            else if (i_wb_adr == SSLC_IDX_LINE)
            begin
                line_reg <= sslc_merge(line_reg, i_wb_dat, i_wb_sel);
            end
            else if (i_wb_adr == SSLC_IDX_CTRL)
            begin
                ctrl_reg <= sslc_merge(ctrl_reg, i_wb_dat, i_wb_sel) & 16'h0001;
            end
        end
    end

    // Divider phase captured only while sync procedure runs
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            phase_reg <= 2'b00;
        end
        else if (o_align_enable && i_sync)
        begin
            phase_reg <= i_divider_phase;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always_comb
    begin
        rd_next = 16'h0000;
        if (i_wb_adr == SSLC_IDX_SCAN)
        begin
            rd_next = scan_reg;
        end
        else if (i_wb_adr == SSLC_IDX_RSVD)
        begin
            rd_next = rsvd_reg;
        end
        else if (i_wb_adr == SSLC_IDX_ALIGN)
        begin
            rd_next = align_reg;
            rd_next[SSLC_PH_HI:SSLC_PH_LO] = phase_reg;
        end
        else if (i_wb_adr == SSLC_IDX_LINE)
        begin
            rd_next = line_reg;
        end
        else if (i_wb_adr == SSLC_IDX_CTRL)
        begin
            rd_next = ctrl_reg;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            rdat_reg <= 32'h0000_0000;
        end
        else if (req && !i_wb_we)
        begin
            rdat_reg <= {16'h0000, rd_next};
        end
    end

    // Scan load strobe follows a write to the scan register
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_scan_load <= 1'b0;
        end
        else
        begin
            o_scan_load <= wr && (i_wb_adr == SSLC_IDX_SCAN);
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdat_reg;
    assign o_scan_vector = scan_reg;
    assign o_align_enable = align_reg[SSLC_SDE_BIT];
    assign o_sync_delay_enable = align_reg[SSLC_SDE_BIT];
    // Delay forced to zero when disabled to cut power
    assign o_sync_delay_value = align_reg[SSLC_SDE_BIT] ?
        align_reg[SSLC_SDV_HI:SSLC_SDV_LO] : 8'h00;
    // Sync ignored while disabled
    assign o_training_mode = align_reg[SSLC_SDE_BIT] & i_sync
        & ~ctrl_reg[SSLC_TD_BIT];
    assign o_line_preemphasis_level = line_reg[SSLC_EM_HI:SSLC_EM_LO];
    assign o_line_common_level_sel = line_reg[SSLC_CM_HI:SSLC_CM_LO];
    assign o_line_swing_sel = line_reg[SSLC_SW_HI:SSLC_SW_LO];
    assign o_lane_test_config = line_reg[SSLC_TL_HI:SSLC_TL_LO];
endmodule // sslc_regs

//--- rtl/sslc_pkg.sv
// Package of offsets, fields and reset values for the lane config registers
// Notes on behaviour
// - Scan access register reads and writes the 16-bit calibration scan vector.
// - Sync enable one turns on training pattern, alignment and sync delay.
// - Sync enable zero disables alignment and ignores sync activity.
// - Sync delay code sits in bits 14 to 7, zero means no delay.
// - Bits 6 to 5 read back divider phase during sync, read only.
// - Bits 15 to 14 of driver config select de-emphasis level.
// - Bits 13 to 12 of driver config select common-mode level.
// - Bits 11 to 10 of driver config select differential swing.
// - Bits 9 to 0 configure lane test features with test mode and tables.
// - Sync input enters training pattern unless training disable is one.
package sslc_pkg;
    // ****************************************
    // Register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [7:0] SSLC_IDX_SCAN = 8'h0e;
    localparam logic [7:0] SSLC_IDX_RSVD = 8'h0f;
    localparam logic [7:0] SSLC_IDX_ALIGN = 8'h10;
    localparam logic [7:0] SSLC_IDX_LINE = 8'h11;
    localparam logic [7:0] SSLC_IDX_CTRL = 8'h20;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] SSLC_RST_SCAN = 16'h0000;
    localparam logic [15:0] SSLC_RST_RSVD = 16'h0001;
    localparam logic [15:0] SSLC_RST_ALIGN = 16'h8000;
    localparam logic [15:0] SSLC_RST_LINE = 16'h0000;
    localparam logic [15:0] SSLC_RST_CTRL = 16'h0000;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int SSLC_SDE_BIT = 15;
    localparam int SSLC_SDV_HI = 14;
    localparam int SSLC_SDV_LO = 7;
    localparam int SSLC_PH_HI = 6;
    localparam int SSLC_PH_LO = 5;
    localparam int SSLC_EM_HI = 15;
    localparam int SSLC_EM_LO = 14;
    localparam int SSLC_CM_HI = 13;
    localparam int SSLC_CM_LO = 12;
    localparam int SSLC_SW_HI = 11;
    localparam int SSLC_SW_LO = 10;
    localparam int SSLC_TL_HI = 9;
    localparam int SSLC_TL_LO = 0;
    localparam int SSLC_TD_BIT = 0;
endpackage

//--- sim/sslc_regs_properties.sv
// Port relations checker for the lane config register slice
`timescale 1ns/1ns
module sslc_regs_chk
import sslc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic o_wb_ack,
    input wire logic i_sync,
    input wire logic [15:0] o_scan_vector,
    input wire logic o_scan_load,
    input wire logic o_align_enable,
    input wire logic o_sync_delay_enable,
    input wire logic [7:0] o_sync_delay_value,
    input wire logic o_training_mode,
    input wire logic [1:0] o_line_preemphasis_level,
    input wire logic [1:0] o_line_common_level_sel,
    input wire logic [1:0] o_line_swing_sel,
    input wire logic [9:0] o_lane_test_config
);
    logic w;
    logic [15:0] line;
    assign w = o_wb_ack && i_wb_we;
    assign line = {o_line_preemphasis_level, o_line_common_level_sel,
        o_line_swing_sel, o_lane_test_config};
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    a_scan_write: assert property (w && i_wb_adr == SSLC_IDX_SCAN
        |-> o_scan_vector == i_wb_dat[15:0]) else $error("scan not loaded");
    a_scan_strobe: assert property (w && i_wb_adr == SSLC_IDX_SCAN
        |-> o_scan_load) else $error("scan load strobe missing");
    a_strobe_cause: assert property (o_scan_load
        |-> w && i_wb_adr == SSLC_IDX_SCAN) else $error("stray scan load");
    a_enable_write: assert property (w && i_wb_adr == SSLC_IDX_ALIGN
        |-> o_align_enable == i_wb_dat[15] && o_sync_delay_enable == i_wb_dat[15])
        else $error("sync enable not taken");
    a_sync_off: assert property (!o_align_enable |-> !o_training_mode
        && o_sync_delay_value == 8'h00) else $error("sync parts left on");
    a_delay_code: assert property (w && i_wb_adr == SSLC_IDX_ALIGN
        && i_wb_dat[15] |-> o_sync_delay_value == i_wb_dat[14:7])
        else $error("delay code wrong");
    a_driver_fields: assert property (w && i_wb_adr == SSLC_IDX_LINE
        |-> line == i_wb_dat[15:0]) else $error("driver fields wrong");
    a_train_cause: assert property (o_training_mode
        |-> i_sync && o_align_enable) else $error("training without sync");
    a_reset_load: assert property (disable iff (1'b0) !i_rst_b
        |=> o_align_enable && o_scan_vector == 16'h0000 && line == 16'h0000)
        else $error("reset values wrong");
endmodule // sslc_regs_chk
bind sslc_regs sslc_regs_chk chk (.*);

//--- sim/sslc_host.sv
// Host model that masters the register bus
`timescale 1ns/1ns
module sslc_host
import sslc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_ack,
    input wire logic [31:0] i_rdat,
    output logic o_cyc,
    output logic o_we,
    output logic [7:0] o_adr,
    output logic [31:0] o_dat
);
    initial {o_cyc, o_we, o_adr, o_dat} = '0;
    // Holds the request until ack is sampled, then idles a cycle
    task xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
        output logic [31:0] q);
        o_cyc <= 1'b1;
        o_we <= w;
        o_adr <= a;
        o_dat <= {16'h0000, a == SSLC_IDX_ALIGN ? d & 16'hffe0 : d};
        do @(posedge i_clk); while (i_ack !== 1'b1);
        q = i_rdat;
        o_cyc <= 1'b0;
        @(posedge i_clk);
    endtask
    task init_rsvd(output logic [31:0] q);
        xfer(1'b1, SSLC_IDX_RSVD, 16'h0001, q);
    endtask
endmodule // sslc_host

//--- sim/testbench.sv
// Self-checking bench for the lane config register slice
`timescale 1ns/1ns
module testbench;
    import sslc_pkg::*;
    logic clk = 0, rst_b = 0, sync = 0, cyc, we, ack, align, sync_delay_enable, train;
    logic [1:0] phase = 0, em, cm, sw;
    logic [7:0] adr, sync_delay_value;
    logic [9:0] tl;
    logic [15:0] scan, d;
    logic [31:0] dat, rdat, q;
    int errors = 0, n_checks = 0;
    always #5 clk = ~clk;
    sslc_host h (.i_clk(clk), .i_ack(ack), .i_rdat(rdat), .o_cyc(cyc),
        .o_we(we), .o_adr(adr), .o_dat(dat));
    sslc_regs uut (.i_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc),
        .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h3),
        .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_sync(sync),
        .i_divider_phase(phase), .o_scan_vector(scan), .o_scan_load(),
        .o_align_enable(align), .o_sync_delay_enable(sync_delay_enable),
        .o_sync_delay_value(sync_delay_value), .o_training_mode(train),
        .o_line_preemphasis_level(em), .o_line_common_level_sel(cm),
        .o_line_swing_sel(sw), .o_lane_test_config(tl));
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
            errors++;
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        h.xfer(1'b0, a, 16'h0000, q);
        chk("read", e, q);
    endtask
    task t_reset;
        rd(SSLC_IDX_SCAN, {16'h0000, SSLC_RST_SCAN});
        rd(SSLC_IDX_ALIGN, {16'h0000, SSLC_RST_ALIGN});
        rd(SSLC_IDX_LINE, {16'h0000, SSLC_RST_LINE});
        rd(SSLC_IDX_RSVD, {16'h0000, SSLC_RST_RSVD});
        rd(SSLC_IDX_CTRL, {16'h0000, SSLC_RST_CTRL});
        rd(8'h21, 32'h0000_0000);
    endtask
    task t_scan;
        h.xfer(1'b1, SSLC_IDX_SCAN, 16'ha5c3, q);
        chk("scan", 32'h0000_a5c3, {16'h0000, scan});
        rd(SSLC_IDX_SCAN, 32'h0000_a5c3);
        h.init_rsvd(q);
        rd(SSLC_IDX_RSVD, 32'h0000_0001);
    endtask
    task t_align;
        sync <= 1'b1;
        h.xfer(1'b1, SSLC_IDX_ALIGN, 16'h0000, q);
        chk("off", 32'h0000_0000, {21'h0, align, sync_delay_enable, sync_delay_value, train});
        h.xfer(1'b1, SSLC_IDX_ALIGN, 16'hff80, q);
        chk("on", 32'h0000_07ff, {21'h0, align, sync_delay_enable, sync_delay_value, train});
        for (int p = 0; p < 4; p++)
        begin
            phase <= p[1:0];
            @(posedge clk);
            rd(SSLC_IDX_ALIGN, 32'(32'h0000_ff80 + p * 32));
        end
        h.xfer(1'b1, SSLC_IDX_CTRL, 16'h0001, q);
        chk("tdis", 32'h0000_0000, {31'h0, train});
        h.xfer(1'b1, SSLC_IDX_CTRL, 16'h0000, q);
        sync <= 1'b0;
    endtask
    task t_line;
        for (int c = 0; c < 4; c++)
        begin
            d = {c[1:0], ~c[1:0], c[1:0], 10'h2a5 ^ {5{c[1:0]}}};
            h.xfer(1'b1, SSLC_IDX_LINE, d, q);
            chk("line", {16'h0000, d}, {16'h0000, em, cm, sw, tl});
        end
    endtask
    task print_verdict;
        $display("errors=%0d checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #20000;
        errors++;
        print_verdict;
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_scan;
        t_align;
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_line;
        print_verdict;
    end
endmodule // testbench
